/* File: rtl/pmc_pkg.sv */
// constants and types shared by the power mode and clock divider control
package pmc_pkg;

   // ****************************************
   // bus shape
   // ****************************************
   localparam int PMC_ADDR_W = 12;
   localparam int PMC_DATA_W = 32;
   localparam int PMC_IDX_W  = 10;

   // ****************************************
   // register indices, byte address = 4 * index
   // ****************************************
   localparam logic [PMC_IDX_W-1:0] PMC_IDX_PWRCTL = 10'h087;
   localparam logic [PMC_IDX_W-1:0] PMC_IDX_CKDIV  = 10'h08f;
   localparam logic [PMC_IDX_W-1:0] PMC_IDX_STATUS = 10'h090;

   // decoder result codes
   localparam logic [1:0] PMC_SEL_NONE   = 2'h0;
   localparam logic [1:0] PMC_SEL_PWRCTL = 2'h1;
   localparam logic [1:0] PMC_SEL_CKDIV  = 2'h2;
   localparam logic [1:0] PMC_SEL_STATUS = 2'h3;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int PMC_PWR_IDLE_BIT = 0;
   localparam int PMC_PWR_PD_BIT   = 1;
   localparam int PMC_CK_CPU_BIT   = 0;
   localparam int PMC_CK_PERIPH_LO = 1;
   localparam int PMC_N_PERIPH     = 7;
   localparam logic [7:0] PMC_PWR_RESET = 8'h00;
   localparam logic [7:0] PMC_CK_RESET  = 8'h00;

   localparam int PMC_ST_IDLE_BIT = 0;
   localparam int PMC_ST_PD_BIT   = 1;
   localparam int PMC_ST_WAKE_BIT = 2;
   localparam int PMC_ST_FAST_BIT = 3;
   localparam int PMC_ST_OPT_BIT  = 4;

   // ****************************************
   // timing
   // ****************************************
   localparam int PMC_WAKE_HOLD_CLKS = 1024;
   localparam int PMC_SLOW_DIV       = 12;
   localparam int PMC_FAST_DIV       = 6;

   typedef enum logic [3:0] {
      PMC_RUN    = 4'b0001,
      PMC_IDLE   = 4'b0010,
      PMC_PDOWN  = 4'b0100,
      PMC_PDEXIT = 4'b1000
   } pmc_state_t;

endpackage

/* File: rtl/pmc_cycle_gen.sv */
// machine cycle enable generator, six or twelve clocks per cycle per output
`timescale 1ns/1ps
module pmc_cycle_gen #(
   parameter int N_OUT = 8
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             run,
   input  wire logic [N_OUT-1:0] six_sel,
   output logic      [N_OUT-1:0] cyc_en
);
   import pmc_pkg::*;

   // ****************************************
   // shared phase counter
   // ****************************************
   localparam logic [3:0] LAST_SLOW = 4'(PMC_SLOW_DIV - 1);
   localparam logic [3:0] LAST_FAST = 4'(PMC_FAST_DIV - 1);

   logic [3:0] phase_q;

   // one shared phase keeps six and twelve clock users aligned
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= 4'h0;
      end else if (phase_q == LAST_SLOW) begin
         phase_q <= 4'h0;
      end else begin
         phase_q <= phase_q + 4'h1;
      end
   end

   // ****************************************
   // per output enables
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < N_OUT; i++) begin : g_en
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cyc_en[i] <= 1'b0;
            end else begin
               cyc_en[i] <= run && ((phase_q == LAST_SLOW) ||
                            (six_sel[i] && phase_q == LAST_FAST));
            end
         end
      end
   endgenerate

endmodule

/* File: rtl/pmc_top.sv */
// power mode and clock divider control, apb register slave
//
// How it works
// [R1] idle request halts pc, clocks keep running
// [R2] ram and registers untouched during idle
// [R3] interrupt service start clears idle, resumes
// [R4] hardware reset ends idle or power-down
// [R5] power-down request stops the clock
// [R6] power-down keeps state, level wake only
// [R7] level wake ends power-down, service clears bit
// [R8] wake pin low 1024 clocks before high
// [R9] pin high again runs service, then resumes
// [R10] idle holds both strobes high
// [R11] power-down holds both strobes low
// [R12] cpu select bit0: 0 twelve, 1 six
// [R13] fast option forces six, bit ignored
// [R14] bits 7..1 pick peripheral 6 or 12
// [R15] cpu twelve forces peripherals to twelve
// [R16] both requests set: power-down wins
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module pmc_top (
   input  wire logic                            CLK,
   input  wire logic                            ARST_N,
   input  wire logic                            PSEL,
   input  wire logic                            PENABLE,
   input  wire logic                            PWRITE,
   input  wire logic [pmc_pkg::PMC_ADDR_W-1:0]  PADDR,
   input  wire logic [pmc_pkg::PMC_DATA_W-1:0]  PWDATA,
   output logic      [pmc_pkg::PMC_DATA_W-1:0]  PRDATA,
   output logic                                 PREADY,
   output logic                                 PSLVERR,
   input  wire logic                            FAST_CLOCK_OPT,
   input  wire logic                            INT_SERVICE_START,
   input  wire logic [1:0]                      EXT_INT_N,
   input  wire logic [1:0]                      EXT_INT_ENABLE,
   input  wire logic [1:0]                      EXT_INT_LEVEL_MODE,
   input  wire logic                            ADDR_LATCH_IN,
   input  wire logic                            PROGRAM_STORE_STROBE_IN,
   output logic                                 ADDR_LATCH_STROBE,
   output logic                                 PROGRAM_STORE_STROBE,
   output logic                                 CPU_HALT,
   output logic                                 CPU_CLOCK_RUN,
   output logic                                 PERIPH_CLOCK_RUN,
   output logic                                 WAKE_REQUEST,
   output logic                                 CPU_CYCLE_EN,
   output logic [pmc_pkg::PMC_N_PERIPH-1:0]     PERIPH_CYCLE_EN
);
   import pmc_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   localparam logic [10:0] WAKE_HOLD = 11'(PMC_WAKE_HOLD_CLKS);

   logic                    setup_phase;
   logic                    access_done;
   logic                    wr_done;
   logic [1:0]              sel_now;
   logic                    pready_q;
   logic                    pslverr_q;
   logic [PMC_DATA_W-1:0]   prdata_q;
   logic [PMC_DATA_W-1:0]   rd_mux;

   logic                    idle_req_q;
   logic                    pd_req_q;
   logic                    idle_set;
   logic                    pd_set;
   logic [7:0]              ckdiv_q;

   pmc_state_t              state_q;
   pmc_state_t              state_d;
   logic [10:0]             hold_cnt_q;
   logic                    hold_met;
   logic                    wake_low;

   logic                    cpu_fast;
   logic [PMC_N_PERIPH:0]   six_sel;
   logic [PMC_N_PERIPH:0]   cyc_en;
   logic                    gen_run;

   logic                    halt_q;
   logic                    cpu_run_q;
   logic                    per_run_q;
   logic                    ale_q;
   logic                    pss_q;
   logic                    wake_q;

   // ****************************************
   // address decode
   // ****************************************
   function automatic logic [1:0] pmc_decode(
      input logic [PMC_ADDR_W-1:0] addr
   );
      logic [PMC_IDX_W-1:0] idx;
      idx = addr[PMC_ADDR_W-1:2];
      if (addr[1:0] != 2'h0) begin
         pmc_decode = PMC_SEL_NONE;
      end else if (idx == PMC_IDX_PWRCTL) begin
         pmc_decode = PMC_SEL_PWRCTL;
      end else if (idx == PMC_IDX_CKDIV) begin
         pmc_decode = PMC_SEL_CKDIV;
      end else if (idx == PMC_IDX_STATUS) begin
         pmc_decode = PMC_SEL_STATUS;
      end else begin
         pmc_decode = PMC_SEL_NONE;
      end
   endfunction

   // ****************************************
   // apb handshake
   // ****************************************
   assign setup_phase = PSEL && !PENABLE;
   assign access_done = PSEL && PENABLE && pready_q;
   assign sel_now     = pmc_decode(PADDR);
   assign wr_done     = access_done && PWRITE;

   // one wait-free access phase: ready rises in the cycle after setup
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= setup_phase;
      end
   end

   // unmapped or misaligned addresses answer with an error
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= setup_phase && (sel_now == PMC_SEL_NONE);
      end
   end

   always_comb begin
      rd_mux = '0;
      if (sel_now == PMC_SEL_PWRCTL) begin
         rd_mux[PMC_PWR_IDLE_BIT] = idle_req_q;
         rd_mux[PMC_PWR_PD_BIT]   = pd_req_q;
      end else if (sel_now == PMC_SEL_CKDIV) begin
         rd_mux[7:0] = ckdiv_q;
      end else if (sel_now == PMC_SEL_STATUS) begin
         rd_mux[PMC_ST_IDLE_BIT] = (state_q == PMC_IDLE);
         rd_mux[PMC_ST_PD_BIT]   = (state_q == PMC_PDOWN);
         rd_mux[PMC_ST_WAKE_BIT] = wake_q;
         rd_mux[PMC_ST_FAST_BIT] = cpu_fast;
         rd_mux[PMC_ST_OPT_BIT]  = FAST_CLOCK_OPT;
      end
   end

   // read data captured in setup, held through the access phase
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prdata_q <= '0;
      end else if (setup_phase) begin
         prdata_q <= PWRITE ? '0 : rd_mux;
      end
   end

   // ****************************************
   // power control requests
   // ****************************************
   assign idle_set = wr_done && (sel_now == PMC_SEL_PWRCTL) &&
                     PWDATA[PMC_PWR_IDLE_BIT];
   assign pd_set   = wr_done && (sel_now == PMC_SEL_PWRCTL) &&
                     PWDATA[PMC_PWR_PD_BIT];

   // software sets, service start clears; a set in the same cycle wins
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         idle_req_q <= PMC_PWR_RESET[PMC_PWR_IDLE_BIT];  // [R4]
      end else if (idle_set) begin
         idle_req_q <= 1'b1;  // [R1]
      end else if (INT_SERVICE_START) begin
         idle_req_q <= 1'b0;  // [R3]
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pd_req_q <= PMC_PWR_RESET[PMC_PWR_PD_BIT];  // [R4]
      end else if (pd_set) begin
         pd_req_q <= 1'b1;  // [R5]
      end else if (INT_SERVICE_START && state_q != PMC_PDOWN) begin
         pd_req_q <= 1'b0;  // [R7]
      end
   end

   // ****************************************
   // clock divide select
   // ****************************************
   // only bus writes touch it, so it holds through idle and power-down
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ckdiv_q <= PMC_CK_RESET;
      end else if (wr_done && sel_now == PMC_SEL_CKDIV) begin
         ckdiv_q <= PWDATA[7:0];  // [R2]
      end
   end

   // ****************************************
   // wake pin qualification
   // ****************************************
   // only enabled pins in level mode may wake a stopped clock
   assign wake_low = |(~EXT_INT_N & EXT_INT_ENABLE & EXT_INT_LEVEL_MODE); // [R6]
   assign hold_met = (hold_cnt_q >= WAKE_HOLD);

   // saturating count of low clocks; a short pulse is discarded
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         hold_cnt_q <= 11'h000;
      end else if (state_q != PMC_PDOWN) begin
         hold_cnt_q <= 11'h000;
      end else if (wake_low) begin
         if (!hold_met) begin
            hold_cnt_q <= hold_cnt_q + 11'h001;  // [R8]
         end
      end else if (!hold_met) begin
         hold_cnt_q <= 11'h000;
      end
   end

   // ****************************************
   // mode state machine
   // ****************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         PMC_RUN: begin
            if (pd_req_q) begin
               state_d = PMC_PDOWN;  // [R16]
            end else if (idle_req_q) begin
               state_d = PMC_IDLE;  // [R1]
            end
         end
         PMC_IDLE: begin
            if (pd_req_q) begin
               state_d = PMC_PDOWN;  // [R16]
            end else if (!idle_req_q) begin
               state_d = PMC_RUN;  // [R3]
            end
         end
         PMC_PDOWN: begin
            if (hold_met && !wake_low) begin
               state_d = PMC_PDEXIT;  // [R9]
            end
         end
         PMC_PDEXIT: begin
            if (!pd_req_q) begin
               state_d = PMC_RUN;  // [R7]
            end
         end
         default: begin
            state_d = PMC_RUN;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q <= PMC_RUN;  // [R4]
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // core controls
   // ****************************************
   // pc held in idle and power-down; released for the wake service
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= (state_d == PMC_IDLE) || (state_d == PMC_PDOWN); // [R1]
      end
   end

   // clock gates for core and peripherals, closed only in power-down
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cpu_run_q <= 1'b1;
      end else begin
         cpu_run_q <= (state_d != PMC_PDOWN);  // [R5]
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         per_run_q <= 1'b1;
      end else begin
         per_run_q <= (state_d != PMC_PDOWN);  // [R1]
      end
   end

   // wake request stands until the core starts its service
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= (state_d == PMC_PDEXIT) && pd_req_q;  // [R9]
      end
   end

   // ****************************************
   // external strobes
   // ****************************************
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ale_q <= 1'b1;
      end else if (state_d == PMC_PDOWN) begin
         ale_q <= 1'b0;  // [R11]
      end else if (state_d == PMC_IDLE) begin
         ale_q <= 1'b1;  // [R10]
      end else begin
         ale_q <= ADDR_LATCH_IN;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pss_q <= 1'b1;
      end else if (state_d == PMC_PDOWN) begin
         pss_q <= 1'b0;  // [R11]
      end else if (state_d == PMC_IDLE) begin
         pss_q <= 1'b1;  // [R10]
      end else begin
         pss_q <= PROGRAM_STORE_STROBE_IN;
      end
   end

   // ****************************************
   // machine cycle enables
   // ****************************************
   // the option pin overrides the register bit outright
   assign cpu_fast = FAST_CLOCK_OPT | ckdiv_q[PMC_CK_CPU_BIT];  // [R12] [R13]

   // index 0 is the cpu, 1..7 follow the register bit order
   always_comb begin
      six_sel = '0;
      six_sel[0] = cpu_fast;  // [R12]
      for (int k = PMC_CK_PERIPH_LO; k <= PMC_N_PERIPH; k++) begin
         six_sel[k] = cpu_fast && !ckdiv_q[k];  // [R14] [R15]
      end
   end

   // stopped clock means no cycle enables at all
   assign gen_run = (state_d != PMC_PDOWN);  // [R5]

   pmc_cycle_gen #(
      .N_OUT   (PMC_N_PERIPH + 1)
   ) u_cycle_gen (
      .clk     (CLK),
      .arst_n  (ARST_N),
      .run     (gen_run),
      .six_sel (six_sel),
      .cyc_en  (cyc_en)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign PREADY               = pready_q;
   assign PSLVERR              = pslverr_q;
   assign PRDATA               = prdata_q;
   assign CPU_HALT             = halt_q;
   assign CPU_CLOCK_RUN        = cpu_run_q;
   assign PERIPH_CLOCK_RUN     = per_run_q;
   assign WAKE_REQUEST         = wake_q;
   assign ADDR_LATCH_STROBE    = ale_q;
   assign PROGRAM_STORE_STROBE = pss_q;
   assign CPU_CYCLE_EN         = cyc_en[0];
   assign PERIPH_CYCLE_EN      = cyc_en[PMC_N_PERIPH:1];

endmodule

/* File: sim/pmc_top_asserts.sv */
// concurrent checks on the power mode and clock divider ports
`timescale 1ns/1ps
module pmc_top_asserts
   import pmc_pkg::*;
(
   input wire logic                          CLK,
   input wire logic                          ARST_N,
   input wire logic                          PSEL,
   input wire logic                          PENABLE,
   input wire logic                          PWRITE,
   input wire logic [pmc_pkg::PMC_ADDR_W-1:0] PADDR,
   input wire logic [pmc_pkg::PMC_DATA_W-1:0] PWDATA,
   input wire logic                          PREADY,
   input wire logic                          FAST_CLOCK_OPT,
   input wire logic                          INT_SERVICE_START,
   input wire logic                          ADDR_LATCH_STROBE,
   input wire logic                          PROGRAM_STORE_STROBE,
   input wire logic                          CPU_HALT,
   input wire logic                          CPU_CLOCK_RUN,
   input wire logic                          PERIPH_CLOCK_RUN,
   input wire logic                          WAKE_REQUEST,
   input wire logic                          CPU_CYCLE_EN,
   input wire logic [pmc_pkg::PMC_N_PERIPH-1:0] PERIPH_CYCLE_EN
);
   // ****************************************
   // shadow of the clock select register
   // ****************************************
   logic       wr_acc;
   logic       pwr_wr;
   logic       six;
   logic       six_q;
   logic [7:0] ck_q;
   logic [3:0] stab_q;
   logic       settled;
   assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
   assign pwr_wr = wr_acc && (PADDR == {PMC_IDX_PWRCTL, 2'b00})
                   && (PWDATA[1:0] != 2'b00);
   assign six = FAST_CLOCK_OPT || ck_q[0];
   // enables lag the select by one cycle, so both copies must agree
   assign settled = (stab_q == 4'hf) && (six == six_q);
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ck_q <= 8'h00;
      end else if (wr_acc && PADDR == {PMC_IDX_CKDIV, 2'b00}) begin
         ck_q <= PWDATA[7:0];
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         six_q  <= 1'b0;
         stab_q <= 4'h0;
      end else begin
         six_q <= six;
         if (six != six_q) begin
            stab_q <= 4'h0;
         end else if (stab_q != 4'hf) begin
            stab_q <= stab_q + 4'h1;
         end
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   a_halt_cause: assert property (
      $rose(CPU_HALT) |-> $past(pwr_wr, 2) || $past(pwr_wr, 3))
      else $error("halt rose without a mode request");
   a_idle_strobes: assert property (
      CPU_HALT && CPU_CLOCK_RUN |-> ADDR_LATCH_STROBE && PROGRAM_STORE_STROBE)
      else $error("strobes not high in idle");
   a_pd_strobes: assert property (
      !CPU_CLOCK_RUN |-> CPU_HALT && !ADDR_LATCH_STROBE
                         && !PROGRAM_STORE_STROBE)
      else $error("strobes not low in power-down");
   a_pd_cycles: assert property (
      !PERIPH_CLOCK_RUN [*2] |-> !CPU_CYCLE_EN && PERIPH_CYCLE_EN == 7'h00)
      else $error("cycle enables run in power-down");
   a_cpu_fast: assert property (
      settled && six && CPU_CYCLE_EN
      |-> ##6 (CPU_CYCLE_EN || !settled || !PERIPH_CLOCK_RUN))
      else $error("six clock cpu pulse missing");
   a_cpu_slow: assert property (
      settled && !six && CPU_CYCLE_EN |=> (!CPU_CYCLE_EN || !settled) [*8])
      else $error("twelve clock cpu pulsed early");
   a_periph_six: assert property (
      settled && six && CPU_CYCLE_EN
      |-> (PERIPH_CYCLE_EN | $past(ck_q[7:1])) == 7'h7f)
      else $error("six clock peripheral pulse missing");
   a_periph_twelve: assert property (
      settled && !six && CPU_CYCLE_EN |-> PERIPH_CYCLE_EN == 7'h7f)
      else $error("peripheral not forced to twelve");
   a_wake_exit: assert property (
      $rose(WAKE_REQUEST) |-> !CPU_HALT && CPU_CLOCK_RUN && PERIPH_CLOCK_RUN)
      else $error("wake pending while halted");
   a_wake_hold: assert property (
      $fell(WAKE_REQUEST)
      |-> $past(INT_SERVICE_START, 2) || $past(INT_SERVICE_START, 3))
      else $error("wake cleared without service");
endmodule

bind pmc_top pmc_top_asserts u_asserts (
   .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
   .FAST_CLOCK_OPT(FAST_CLOCK_OPT), .INT_SERVICE_START(INT_SERVICE_START),
   .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE),
   .PROGRAM_STORE_STROBE(PROGRAM_STORE_STROBE), .CPU_HALT(CPU_HALT),
   .CPU_CLOCK_RUN(CPU_CLOCK_RUN), .PERIPH_CLOCK_RUN(PERIPH_CLOCK_RUN),
   .WAKE_REQUEST(WAKE_REQUEST), .CPU_CYCLE_EN(CPU_CYCLE_EN),
   .PERIPH_CYCLE_EN(PERIPH_CYCLE_EN)
);

/* File: sim/pmc_core_model.sv */
// behavioural cpu core: strobes and interrupt service starts
`timescale 1ns/1ps
module pmc_core_model (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       wake,
   input  wire logic       irq,
   input  wire logic [3:0] lat,
   output logic            svc,
   output logic            ale,
   output logic            pss
);
   logic [3:0] cnt_q;
   logic       pend_q;
   logic       wake_q;
   // strobes toggle every cycle so a stale pass-through shows
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ale <= 1'b0;
         pss <= 1'b1;
      end else begin
         ale <= ~ale;
         pss <= ~pss;
      end
   end
   // one service pulse, lat plus one cycles after a request or a wake edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_q <= 1'b0;
         cnt_q  <= 4'h0;
         svc    <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         svc    <= 1'b0;
         wake_q <= wake;
         if (!pend_q && (irq || (wake && !wake_q))) begin
            pend_q <= 1'b1;
            cnt_q  <= lat;
         end else if (pend_q && cnt_q == 4'h0) begin
            svc    <= 1'b1;
            pend_q <= 1'b0;
         end else if (pend_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule

/* File: sim/pmc_top_test.sv */
// self-checking bench for the power mode and clock divider control
`timescale 1ns/1ps
module pmc_top_test;
   import pmc_pkg::*;
   localparam logic [11:0] A_PWR = {PMC_IDX_PWRCTL, 2'b00};
   localparam logic [11:0] A_CK  = {PMC_IDX_CKDIV, 2'b00};
   localparam logic [11:0] A_ST  = {PMC_IDX_STATUS, 2'b00};
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        fast_opt = 1'b0;
   logic [1:0]  ext_n = 2'b11;
   logic [1:0]  ext_en = 2'b01;
   logic [1:0]  ext_lvl = 2'b11;
   logic        irq = 1'b0;
   logic [3:0]  lat = 4'h0;
   logic [31:0] prdata;
   logic [6:0]  per_en;
   logic        pready, pslverr, svc, ale_in, pss_in, ale, pss;
   logic        halt, cpu_run, per_run, wake, cpu_en;
   logic [31:0] rd, d;
   logic        er, six;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          seed = 32'h0fd9d155;
   int          k;
   int          cnt[8];

   always #2 clk = ~clk;

   pmc_top dut (
      .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .FAST_CLOCK_OPT(fast_opt),
      .INT_SERVICE_START(svc), .EXT_INT_N(ext_n), .EXT_INT_ENABLE(ext_en),
      .EXT_INT_LEVEL_MODE(ext_lvl), .ADDR_LATCH_IN(ale_in),
      .PROGRAM_STORE_STROBE_IN(pss_in), .ADDR_LATCH_STROBE(ale),
      .PROGRAM_STORE_STROBE(pss), .CPU_HALT(halt), .CPU_CLOCK_RUN(cpu_run),
      .PERIPH_CLOCK_RUN(per_run), .WAKE_REQUEST(wake),
      .CPU_CYCLE_EN(cpu_en), .PERIPH_CYCLE_EN(per_en));

   pmc_core_model core (.clk(clk), .arst_n(arst_n), .wake(wake),
      .irq(irq), .lat(lat), .svc(svc), .ale(ale_in), .pss(pss_in));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic report_and_stop();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (pready !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic pulse_irq();
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
   endtask

   task automatic hold_low(input int p, input int n);
      @(posedge clk);
      ext_n[p] <= 1'b0;
      repeat (n) @(posedge clk);
      ext_n[p] <= 1'b1;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      apb(0, A_CK, 0);
      chk("ckdiv reset", 32'h0, rd);
      apb(1, A_ST, 32'hff);
      apb(0, A_ST, 0);
      chk("status ro", 32'h0, rd);
      apb(1, 12'h100, 32'hff);
      chk("unmapped err", 1, er);
      apb(0, A_CK + 12'h1, 0);
      chk("misaligned err", 1, er);
      chk("misaligned data", 32'h0, rd);
      // random selections, option pin forces six on the last pass
      for (int t = 0; t < 6; t++) begin
         d = $random(seed);
         d[0] = t[1];
         apb(1, A_CK, d);
         fast_opt <= (t == 5);
         apb(0, A_CK, 0);
         chk("ckdiv read", d & 32'hff, rd);
         settle(16);
         cnt = '{default: 0};
         repeat (48) begin
            @(negedge clk);
            cnt[7] += (cpu_en === 1'b1);
            for (int i = 0; i < 7; i++) cnt[i] += (per_en[i] === 1'b1);
         end
         six = (t == 5) || d[0];
         chk("cpu pulses", six ? 8 : 4, cnt[7]);
         for (int i = 0; i < 7; i++) begin
            chk("periph pulses", (six && !d[i+1]) ? 8 : 4, cnt[i]);
         end
         apb(0, A_ST, 0);
         chk("status mode", {27'h0, t == 5, six, 3'b000}, rd);
      end
      fast_opt <= 1'b0;
      apb(1, A_CK, 32'h5a);
      apb(1, A_PWR, 32'h1);
      settle(4);
      chk("idle halt", {1'b1, 1'b1}, {halt, cpu_run});
      chk("idle strobes", 2'b11, {ale, pss});
      pulse_irq();
      settle(12);
      chk("idle exit", 0, halt);
      chk("run strobes", {~ale_in, ~pss_in}, {ale, pss});
      apb(0, A_CK, 0);
      chk("ckdiv kept", 32'h5a, rd);
      apb(1, A_PWR, 32'h3);
      settle(4);
      chk("pd clocks", 0, {cpu_run, per_run});
      chk("pd strobes", 2'b00, {ale, pss});
      apb(0, A_ST, 0);
      chk("pd status", 1, rd[1]);
      pulse_irq();
      hold_low(1, 1100);
      hold_low(0, 1000);
      settle(8);
      chk("pd stays", 0, cpu_run);
      lat <= 4'h7;
      hold_low(0, 1030);
      k = 0;
      while (wake !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      chk("wake seen", 1, wake);
      chk("wake running", 0, halt);
      settle(20);
      chk("wake done", {1'b0, 1'b1}, {wake, cpu_run});
      apb(0, A_ST, 0);
      chk("run status", 32'h0, rd & 32'h7);
      apb(1, A_CK, 32'h81);
      apb(1, A_PWR, 32'h1);
      settle(4);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      settle(1);
      chk("reset halt", 0, halt);
      apb(0, A_CK, 0);
      chk("reset ckdiv", 32'h0, rd);
      report_and_stop();
   end
endmodule
